// [inc/owg_pkg.sv]
package owg_pkg;
   // Register addresses in the function register space
   localparam logic [7:0] ADDR_PROGRAM_STORE_CONTROL = 8'h8F;
   localparam logic [7:0] ADDR_WRITE_KEY_LOCK = 8'hB7;
   localparam logic [7:0] ADDR_IN_APP_PROGRAMMING_CONTROL = 8'hF5;
   // Debug-port register selects
   localparam logic [1:0] DBG_SEL_BYTE_ZERO = 2'h0;
   localparam logic [1:0] DBG_SEL_BYTE_ONE = 2'h1;
   localparam logic [1:0] DBG_SEL_BYTE_TWO = 2'h2;
   localparam logic [1:0] DBG_SEL_BYTE_THREE = 2'h3;
   // Field positions and values
   localparam int STORE_WRITE_SELECT_BIT = 0;
   localparam int IN_APP_PROGRAM_ON_BIT = 7;
   localparam int PROGRAM_HW_OFF_BIT = 6;
   localparam int CHECKSUM_BUSY_BIT = 7;
   localparam logic [7:0] KEY_FIRST = 8'hA5;
   localparam logic [7:0] KEY_SECOND = 8'hF1;
   localparam logic [7:0] REG_RESET = 8'h00;
   localparam logic [7:0] BLOCK_LOW_ADDR = 8'h00;
   // Checksum polynomials and seeds
   localparam logic [15:0] POLY_BLOCK = 16'h1021;
   localparam logic [31:0] POLY_WHOLE = 32'h04C11DB7;
   localparam logic [31:0] CRC_SEED = 32'h00000000;
   // Lock states as reported in the key register
   localparam logic [1:0] LOCK_LOCKED = 2'h0;
   localparam logic [1:0] LOCK_FIRST_KEY = 2'h1;
   localparam logic [1:0] LOCK_UNLOCKED = 2'h2;
   localparam logic [1:0] LOCK_DISABLED = 2'h3;

   // CPU register-space access
   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } owg_sfr_req_s;

   // Code-store byte write request
   typedef struct packed {
      logic [15:0] addr;
      logic [7:0] data;
   } owg_store_wr_s;
endpackage : owg_pkg

// [rtl/owg_crc_engine.sv]
`timescale 1ns/10ps
// One byte per cycle checksum, MSB first, no reflection
module owg_crc_engine
   import owg_pkg::*;
(
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic clear,
   input wire logic wide,
   input wire logic step,
   input wire logic [7:0] data,
   output logic [31:0] crc_q
);
   // Bit-serial update of one byte
   function automatic logic [31:0] crc_byte(input logic [31:0] c, input logic [7:0] d,
                                            input logic w);
      logic [31:0] r;
      logic fb;
      r = c;
      for (int i = 7; i >= 0; i--) begin
         if (w) begin
            fb = r[31] ^ d[i];
            r = {r[30:0], 1'b0} ^ (fb ? POLY_WHOLE : 32'h00000000);
         end else begin
            fb = r[15] ^ d[i];
            r = {16'h0000, r[14:0], 1'b0} ^ {16'h0000, (fb ? POLY_BLOCK : 16'h0000)};
         end
      end
      return r;
   endfunction : crc_byte

   // Remainder register
   always_ff @(posedge clk_sys) begin
      if (reset || clear) begin
         crc_q <= CRC_SEED;
      end else if (step) begin
         crc_q <= crc_byte(crc_q, data, wide);
      end
   end
endmodule : owg_crc_engine

// [rtl/owg_write_guard.sv]
`timescale 1ns/10ps
// How it works
// - Checksums run regardless of code-store lock
// - Block checksum only on aligned 256-byte blocks
// - Byte-one write starts whole-memory checksum
// - Busy flag held during whole checksum
// - 32-bit result: byte three MSB, zero LSB
// - Whole-memory polynomial 0x04C11DB7
// - Byte-zero write starts block, gives high address
// - 16-bit result: byte one MSB, zero LSB
// - Block polynomial 0x1021
// - Write-select bit routes data writes to store
// - Upper seven control bits read zero
// - Keys 0xA5 then 0xF1 unlock writes
// - Relock after each completed store write
// - Bad key or locked write locks permanently
// - Key register reads lock state bits
// - One byte programmed per data write
// - Writing 0x80 enables in-app programming
// - Writing 0x40 releases programming pin
module owg_write_guard
   import owg_pkg::*;
#(
   parameter int ADDR_W = 16,
   parameter logic [15:0] USER_TOP = 16'hFFF7
)
(
   input wire logic clk_sys,
   input wire logic reset,
   input wire owg_sfr_req_s sfr_req,
   output logic [7:0] sfr_rdata_q,
   input wire logic data_move_write,
   input wire owg_store_wr_s data_move_req,
   output logic store_wr_q,
   output owg_store_wr_s store_wr_data_q,
   input wire logic [7:0] store_rdata,
   output logic [15:0] store_raddr_q,
   input wire logic dbg_wr,
   input wire logic [1:0] dbg_sel,
   input wire logic [7:0] dbg_wdata,
   output logic [7:0] debug_address_reg_q,
   output logic [7:0] dbg_rdata_q,
   output logic program_hw_disable_q,
   output logic ram_wr_q,
   output owg_store_wr_s ram_wr_data_q
);
   typedef enum logic [1:0] {
      CRC_IDLE,
      CRC_ADDR,
      CRC_RUN
   } owg_crc_e;

   logic store_write_select_q;
   logic [1:0] lock_q;
   logic in_app_program_on_q;
   owg_crc_e crc_st_q;
   logic crc_wide_q;
   logic [15:0] crc_addr_q;
   logic [15:0] crc_end_q;
   logic crc_step_q;
   logic crc_last_q;
   logic crc_clear;
   logic [31:0] crc_val;
   logic [31:0] result_q;
   logic wr_ctl;
   logic wr_key;
   logic wr_iap;
   logic store_try;

   assign wr_ctl = sfr_req.wr && sfr_req.addr == ADDR_PROGRAM_STORE_CONTROL;
   assign wr_key = sfr_req.wr && sfr_req.addr == ADDR_WRITE_KEY_LOCK;
   assign wr_iap = sfr_req.wr && sfr_req.addr == ADDR_IN_APP_PROGRAMMING_CONTROL;
   assign store_try = data_move_write && store_write_select_q;
   assign crc_clear = crc_st_q == CRC_IDLE && dbg_wr &&
                      (dbg_sel == DBG_SEL_BYTE_ZERO || dbg_sel == DBG_SEL_BYTE_ONE);

   // Program-store control, only bit 0 stored
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         store_write_select_q <= 1'b0;
      end else if (wr_ctl) begin
         store_write_select_q <= sfr_req.wdata[STORE_WRITE_SELECT_BIT];
      end
   end

   // Lock/key state machine
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         lock_q <= LOCK_LOCKED;
      end else if (lock_q != LOCK_DISABLED) begin
         if (store_try) begin
            if (lock_q == LOCK_UNLOCKED && in_app_program_on_q) begin
               lock_q <= LOCK_LOCKED;
            end else begin
               lock_q <= LOCK_DISABLED;
            end
         end else if (wr_key) begin
            if (lock_q == LOCK_LOCKED && sfr_req.wdata == KEY_FIRST) begin
               lock_q <= LOCK_FIRST_KEY;
            end else if (lock_q == LOCK_FIRST_KEY && sfr_req.wdata == KEY_SECOND) begin
               lock_q <= LOCK_UNLOCKED;
            end else begin
               lock_q <= LOCK_DISABLED;
            end
         end
      end
   end

   // Programming control register
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         in_app_program_on_q <= 1'b0;
         program_hw_disable_q <= 1'b0;
      end else if (wr_iap) begin
         in_app_program_on_q <= sfr_req.wdata[IN_APP_PROGRAM_ON_BIT];
         if (sfr_req.wdata[PROGRAM_HW_OFF_BIT]) begin
            program_hw_disable_q <= 1'b1;
         end
      end
   end

   // Store write: exactly one byte per permitted data write
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         store_wr_q <= 1'b0;
         store_wr_data_q <= '0;
         ram_wr_q <= 1'b0;
         ram_wr_data_q <= '0;
      end else begin
         store_wr_q <= store_try && lock_q == LOCK_UNLOCKED && in_app_program_on_q;
         ram_wr_q <= data_move_write && !store_write_select_q;
         if (data_move_write) begin
            store_wr_data_q <= data_move_req;
            ram_wr_data_q <= data_move_req;
         end
      end
   end

   // CPU register read data
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         sfr_rdata_q <= REG_RESET;
      end else if (sfr_req.rd) begin
         case (sfr_req.addr)
            ADDR_PROGRAM_STORE_CONTROL: begin
               sfr_rdata_q <= {7'h00, store_write_select_q};
            end
            ADDR_WRITE_KEY_LOCK: begin
               sfr_rdata_q <= {6'h00, lock_q};
            end
            ADDR_IN_APP_PROGRAMMING_CONTROL: begin
               sfr_rdata_q <= {in_app_program_on_q, program_hw_disable_q, 6'h00};
            end
            default: begin
               sfr_rdata_q <= REG_RESET;
            end
         endcase
      end
   end

   // Checksum sequencer, independent of the lock state
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         crc_st_q <= CRC_IDLE;
         crc_wide_q <= 1'b0;
         crc_addr_q <= 16'h0000;
         crc_end_q <= 16'h0000;
         crc_step_q <= 1'b0;
         crc_last_q <= 1'b0;
      end else begin
         crc_step_q <= 1'b0;
         case (crc_st_q)
            CRC_IDLE: begin
               if (crc_clear && dbg_sel == DBG_SEL_BYTE_ZERO) begin
                  crc_wide_q <= 1'b0;
                  crc_addr_q <= {dbg_wdata, BLOCK_LOW_ADDR};
                  crc_end_q <= {dbg_wdata, 8'hFF};
                  crc_st_q <= CRC_ADDR;
               end else if (crc_clear) begin
                  crc_wide_q <= 1'b1;
                  crc_addr_q <= 16'h0000;
                  crc_end_q <= USER_TOP;
                  crc_st_q <= CRC_ADDR;
               end
            end
            CRC_ADDR: begin
               // Address presented, data valid next cycle
               crc_st_q <= CRC_RUN;
               crc_last_q <= crc_addr_q == crc_end_q;
            end
            CRC_RUN: begin
               crc_step_q <= 1'b1;
               if (crc_last_q) begin
                  crc_st_q <= CRC_IDLE;
               end else begin
                  crc_addr_q <= crc_addr_q + 16'h0001;
                  crc_st_q <= CRC_ADDR;
               end
            end
            default: begin
               crc_st_q <= CRC_IDLE;
            end
         endcase
      end
   end

   // Store read address follows the sequencer
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         store_raddr_q <= 16'h0000;
      end else begin
         store_raddr_q <= crc_addr_q;
      end
   end

   // Busy flag raised at start, held until last byte folded in
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         debug_address_reg_q <= REG_RESET;
      end else if (crc_clear) begin
         debug_address_reg_q[CHECKSUM_BUSY_BIT] <= 1'b1;
      end else if (crc_step_q && crc_st_q == CRC_IDLE) begin
         debug_address_reg_q[CHECKSUM_BUSY_BIT] <= 1'b0;
      end
   end

   // Result latched when the engine finishes
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         result_q <= 32'h00000000;
      end else if (crc_step_q && crc_st_q == CRC_IDLE) begin
         result_q <= crc_wide_q ? crc_val : {16'h0000, crc_val[15:0]};
      end
   end

   // Debug-port result byte read
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         dbg_rdata_q <= REG_RESET;
      end else begin
         case (dbg_sel)
            DBG_SEL_BYTE_ZERO: dbg_rdata_q <= result_q[7:0];
            DBG_SEL_BYTE_ONE: dbg_rdata_q <= result_q[15:8];
            DBG_SEL_BYTE_TWO: dbg_rdata_q <= result_q[23:16];
            DBG_SEL_BYTE_THREE: dbg_rdata_q <= result_q[31:24];
            default: dbg_rdata_q <= REG_RESET;
         endcase
      end
   end

   // Engine folds in the byte read from the store
   owg_crc_engine u_crc (
      .clk_sys(clk_sys),
      .reset(reset),
      .clear(crc_clear),
      .wide(crc_wide_q),
      .step(crc_st_q == CRC_RUN),
      .data(store_rdata),
      .crc_q(crc_val)
   );
endmodule : owg_write_guard

// [sim/otp_write_guard_and_crc_tb.sv]
`timescale 1ns/10ps
module otp_write_guard_and_crc_tb;
   import owg_pkg::*;
   localparam logic [15:0] TOP = 16'h01FF;
   logic clk_sys = 1'b0;
   logic reset = 1'b1;
   owg_sfr_req_s sfr_req = '0;
   logic data_move_write = 1'b0;
   owg_store_wr_s data_move_req = '0;
   logic dbg_wr = 1'b0;
   logic [1:0] dbg_sel = 2'h0;
   logic [7:0] dbg_wdata = 8'h00;
   logic [7:0] sfr_rdata_q, debug_address_reg_q, dbg_rdata_q, store_rdata, b;
   logic [15:0] store_raddr_q;
   logic store_wr_q, ram_wr_q, program_hw_disable_q;
   owg_store_wr_s store_wr_data_q, ram_wr_data_q;
   logic [31:0] v;
   int err_count = 0;
   int cmp_count = 0;
   int n;
   // Clock
   always #20 clk_sys = ~clk_sys;
   owg_write_guard #(.USER_TOP(TOP)) owg_write_guard_i (.clk_sys(clk_sys), .reset(reset),
      .sfr_req(sfr_req), .sfr_rdata_q(sfr_rdata_q), .data_move_write(data_move_write),
      .data_move_req(data_move_req), .store_wr_q(store_wr_q),
      .store_wr_data_q(store_wr_data_q), .store_rdata(store_rdata),
      .store_raddr_q(store_raddr_q), .dbg_wr(dbg_wr), .dbg_sel(dbg_sel),
      .dbg_wdata(dbg_wdata), .debug_address_reg_q(debug_address_reg_q),
      .dbg_rdata_q(dbg_rdata_q), .program_hw_disable_q(program_hw_disable_q),
      .ram_wr_q(ram_wr_q), .ram_wr_data_q(ram_wr_data_q));
   owg_store_model owg_store_model_i (.store_raddr_q(store_raddr_q), .store_rdata(store_rdata));
   // Checksum reference, MSB first, zero seed
   function automatic logic [31:0] ref_crc(bit wide, int first, int last);
      logic [31:0] c;
      logic [7:0] d;
      logic fb;
      c = 32'h00000000;
      for (int a = first; a <= last; a++) begin
         d = a[7:0] ^ a[15:8] ^ 8'h5A;
         for (int i = 7; i >= 0; i--) begin
            fb = (wide ? c[31] : c[15]) ^ d[i];
            c = c << 1;
            if (fb) c = c ^ (wide ? POLY_WHOLE : {16'h0000, POLY_BLOCK});
         end
      end
      return wide ? c : {16'h0000, c[15:0]};
   endfunction : ref_crc
   task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         err_count++;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   endtask : chk
   task tick;
      @(posedge clk_sys);
      #1;
   endtask : tick
   task rst;
      reset = 1'b1;
      repeat (4) tick();
      reset = 1'b0;
   endtask : rst
   task sfr_wr(input logic [7:0] a, input logic [7:0] d);
      sfr_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      tick();
      sfr_req = '0;
      tick();
   endtask : sfr_wr
   task sfr_rd(input logic [7:0] a);
      sfr_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
      tick();
      sfr_req = '0;
      tick();
      b = sfr_rdata_q;
   endtask : sfr_rd
   task move(input logic [15:0] a, input logic [7:0] d, input logic st, input logic rm);
      data_move_write = 1'b1;
      data_move_req = '{addr: a, data: d};
      tick();
      data_move_write = 1'b0;
      chk("store_wr", store_wr_q, st);
      chk("ram_wr", ram_wr_q, rm);
      if (st) chk("store_data", {8'h00, store_wr_data_q}, {8'h00, a, d});
      if (rm) chk("ram_data", {8'h00, ram_wr_data_q}, {8'h00, a, d});
      tick();
   endtask : move
   task crc_run(input logic [1:0] sel, input logic [7:0] d);
      dbg_sel = sel;
      dbg_wdata = d;
      dbg_wr = 1'b1;
      tick();
      dbg_wr = 1'b0;
      chk("busy", debug_address_reg_q[7], 1'b1);
      n = 0;
      while (debug_address_reg_q[7] !== 1'b0 && n < 5000) begin
         tick();
         n++;
      end
      for (int i = 0; i < 4; i++) begin
         dbg_sel = i[1:0];
         tick();
         tick();
         v[8*i +: 8] = dbg_rdata_q;
      end
   endtask : crc_run
   task complete_run;
      $display("checks %0d mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : complete_run
   // Watchdog
   initial begin
      #(40 * 10000);
      err_count++;
      complete_run();
   end
   // Test sequence
   initial begin
      rst();
      sfr_rd(ADDR_PROGRAM_STORE_CONTROL);
      chk("store_ctl_rst", b, REG_RESET);
      sfr_rd(ADDR_WRITE_KEY_LOCK);
      chk("key_rst", b, REG_RESET);
      sfr_rd(8'h10);
      chk("unmapped", b, 8'h00);
      sfr_wr(ADDR_PROGRAM_STORE_CONTROL, 8'hFF);
      sfr_rd(ADDR_PROGRAM_STORE_CONTROL);
      chk("store_ctl", b, 8'h01);
      $display("test registers done");
      sfr_wr(ADDR_WRITE_KEY_LOCK, KEY_FIRST);
      sfr_rd(ADDR_WRITE_KEY_LOCK);
      chk("lock", b[1:0], LOCK_FIRST_KEY);
      sfr_wr(ADDR_WRITE_KEY_LOCK, KEY_SECOND);
      sfr_rd(ADDR_WRITE_KEY_LOCK);
      chk("lock", b[1:0], LOCK_UNLOCKED);
      sfr_wr(ADDR_IN_APP_PROGRAMMING_CONTROL, 8'h80);
      move(16'h1234, 8'h3C, 1'b1, 1'b0);
      sfr_rd(ADDR_WRITE_KEY_LOCK);
      chk("lock", b[1:0], LOCK_LOCKED);
      sfr_wr(ADDR_PROGRAM_STORE_CONTROL, 8'h00);
      move(16'h0055, 8'hC3, 1'b0, 1'b1);
      $display("test store write done");
      sfr_wr(ADDR_WRITE_KEY_LOCK, 8'h33);
      sfr_wr(ADDR_WRITE_KEY_LOCK, KEY_FIRST);
      sfr_wr(ADDR_WRITE_KEY_LOCK, KEY_SECOND);
      sfr_rd(ADDR_WRITE_KEY_LOCK);
      chk("lock", b[1:0], LOCK_DISABLED);
      sfr_wr(ADDR_IN_APP_PROGRAMMING_CONTROL, 8'h40);
      sfr_wr(ADDR_IN_APP_PROGRAMMING_CONTROL, 8'h00);
      chk("hw_off", program_hw_disable_q, 1'b1);
      sfr_rd(ADDR_IN_APP_PROGRAMMING_CONTROL);
      chk("iap_ctl", b, 8'h40);
      crc_run(DBG_SEL_BYTE_ZERO, 8'h01);
      chk("block_len", n, 513);
      chk("block_crc", v, ref_crc(1'b0, 256, 511));
      $display("test block checksum done");
      rst();
      sfr_wr(ADDR_PROGRAM_STORE_CONTROL, 8'h01);
      move(16'h0010, 8'h77, 1'b0, 1'b0);
      sfr_rd(ADDR_WRITE_KEY_LOCK);
      chk("lock", b[1:0], LOCK_DISABLED);
      crc_run(DBG_SEL_BYTE_ONE, 8'h00);
      chk("whole_len", n, 2 * (TOP + 1) + 1);
      chk("whole_crc", v, ref_crc(1'b1, 0, TOP));
      $display("test whole checksum done");
      complete_run();
   end
endmodule : otp_write_guard_and_crc_tb

// [sim/owg_monitor.sv]
`timescale 1ns/10ps
// Port checker for the write guard
module owg_monitor
   import owg_pkg::*;
(
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic data_move_write,
   input wire owg_store_wr_s data_move_req,
   input wire logic store_wr_q,
   input wire owg_store_wr_s store_wr_data_q,
   input wire logic ram_wr_q,
   input wire logic dbg_wr,
   input wire logic [1:0] dbg_sel,
   input wire logic [7:0] debug_address_reg_q,
   input wire logic program_hw_disable_q
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (reset);
   // Busy flag behaviour
   a_busy_on_start: assert property (dbg_wr && dbg_sel[1] == 1'b0 && !debug_address_reg_q[7]
      |=> debug_address_reg_q[7]) else $error("busy not raised");
   a_busy_min_len: assert property ($rose(debug_address_reg_q[7])
      |-> debug_address_reg_q[7] [*8]) else $error("busy too short");
   a_addr_low_zero: assert property (debug_address_reg_q[6:0] == 7'h00)
      else $error("debug address low bits set");
   // Store and RAM write paths and sticky hardware-off flag
   a_store_one_pulse: assert property (store_wr_q |=> !store_wr_q)
      else $error("store write longer than one cycle");
   a_store_cause: assert property (store_wr_q |-> $past(data_move_write)
      && store_wr_data_q == $past(data_move_req)) else $error("store write without cause");
   a_route_excl: assert property (!(store_wr_q && ram_wr_q))
      else $error("write routed twice");
   a_ram_cause: assert property (ram_wr_q |-> $past(data_move_write))
      else $error("ram write without cause");
   a_hw_off_sticky: assert property (program_hw_disable_q |=> program_hw_disable_q)
      else $error("hardware off flag dropped");
   // Main scenarios
   c_crc_done: cover property ($fell(debug_address_reg_q[7]));
   c_store_wr: cover property (store_wr_q);
   c_ram_wr: cover property (ram_wr_q);
endmodule : owg_monitor

bind owg_write_guard owg_monitor owg_monitor_i (.clk_sys(clk_sys), .reset(reset),
   .data_move_write(data_move_write), .data_move_req(data_move_req),
   .store_wr_q(store_wr_q), .store_wr_data_q(store_wr_data_q), .ram_wr_q(ram_wr_q),
   .dbg_wr(dbg_wr), .dbg_sel(dbg_sel), .debug_address_reg_q(debug_address_reg_q),
   .program_hw_disable_q(program_hw_disable_q));

// [sim/owg_store_model.sv]
`timescale 1ns/10ps
// Code store stand-in, readable whatever the lock state
module owg_store_model (
   input wire logic [15:0] store_raddr_q,
   output logic [7:0] store_rdata
);
   // Address-derived content, answers at once
   assign store_rdata = store_raddr_q[7:0] ^ store_raddr_q[15:8] ^ 8'h5A;
endmodule : owg_store_model
